//--- include/mac_upper_regs_pkg.sv
// Register map, field layout and carrier types of the upper register bank
// Notes on behaviour
// - Each specific-address top register keeps address bits 32..47 in bits 15:0, upper half zero.
// - Bit 0 of a bottom register is the multicast flag, matched against bit 0 of the first byte.
// - A 16-bit type/length value is compared with the type/length field of received frames.
// - The pause quantum register resets to 0xffff and feeds generated pause frames.
// - With zero-quantum select set, pause frames carry quantum zero, else the programmed one.
// - Every change of the send-pause bit launches exactly one pause frame.
// - A frame is copied on external match only when the match bit and its enable are both set.
// - Interface select bit 0 chooses reduced interface at zero and full interface at one.
// - Speed, bitrate and loopback read back as mirrors; half duplex reads as inverted full duplex.
// - Bit 20 of the user I/O register shows a detected wake event and ignores writes.
// - Writing one to user I/O bits 0..3 clears them; no write ever sets a bit.
// - Four wake enables each let their receive event assert the wake pin, else it is ignored.
// - A received ARP request whose low 16 target IP bits match the IP field makes a wake event.
// - An IP field of zero never makes a wake event from the IP compare.
// - A read-only version register holds a part field above and a version number below.
// - The block runs from the system bus clock; both bus clocks come from that one tree.
package mac_upper_regs_pkg;

  localparam logic [7:0] ADDR_SA3_HIGH = 8'hac;
  localparam logic [7:0] ADDR_SA4_LOW  = 8'hb0;
  localparam logic [7:0] ADDR_SA4_HIGH = 8'hb4;
  localparam logic [7:0] ADDR_TYPE_LEN = 8'hb8;
  localparam logic [7:0] ADDR_PAUSE_Q  = 8'hbc;
  localparam logic [7:0] ADDR_USER_IO  = 8'hc0;
  localparam logic [7:0] ADDR_WAKE_CFG = 8'hc4;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'hc8;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hcc;
  localparam logic [7:0] ADDR_VERSION  = 8'hfc;

  localparam logic [15:0] PAUSE_Q_RESET  = 16'hffff;
  localparam logic [15:0] WAKE_IP_RESET  = 16'hffff;
  localparam logic [3:0]  WAKE_EN_RESET  = 4'h0;
  // Arbitrary neutral identity values
  localparam logic [15:0] PART_REF_VALUE = 16'h0000;
  localparam logic [15:0] VERSION_VALUE  = 16'h0001;

  // User I/O bit positions
  localparam int UIO_IFSEL  = 0;
  localparam int UIO_EXTM   = 1;
  localparam int UIO_PAUSE  = 2;
  localparam int UIO_ZEROQ  = 3;
  localparam int UIO_LOOPB  = 16;
  localparam int UIO_HALFD  = 17;
  localparam int UIO_BITRT  = 18;
  localparam int UIO_SPEED  = 19;
  localparam int UIO_WAKE   = 20;
  localparam int WAKE_EN_LO = 16;

  // Interrupt status bits
  localparam int IRQ_WAKE  = 0;
  localparam int IRQ_PAUSE = 1;
  localparam int IRQ_SA    = 2;
  localparam int IRQ_TYPE  = 3;

  typedef struct packed {
    logic        dest_valid;
    logic [47:0] dest_addr;
    logic        type_valid;
    logic [15:0] type_len;
  } rx_frame_t;

  typedef struct packed {
    logic        mcast_hash;
    logic        sa1_hit;
    logic        arp_valid;
    logic [15:0] arp_ip;
    logic        magic;
  } wake_src_t;

  typedef struct packed {
    logic speed;
    logic bitrate;
    logic full_duplex_select;
    logic loopback;
    logic external_match_enable;
  } net_cfg_t;

  typedef struct packed {
    logic [15:0] sa3_high;
    logic [31:0] sa4_low;
    logic [15:0] sa4_high;
    logic [15:0] type_length_compare;
    logic [15:0] pause_quantum_value;
    logic [3:0]  user_bits;
    logic        pause_prev;
    logic        wake_event_detected;
    logic [3:0]  wake_en;
    logic [15:0] wake_ip;
    logic [3:0]  irq_status;
    logic [3:0]  irq_mask;
    logic [31:0] rdata;
    logic [1:0]  sa_match;
    logic        type_match;
    logic        pause_req;
    logic [15:0] pause_quantum;
  } state_t;

endpackage

//--- hdl/mac_upper_regs.sv
// Upper MAC register bank: address filters, pause control, user I/O, wake-on-LAN
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module mac_upper_regs
  import mac_upper_regs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire logic [31:0] sa3_low_i,
  input  wire rx_frame_t   rx_i,
  input  wire wake_src_t   wake_i,
  input  wire net_cfg_t    cfg_i,
  input  wire logic [3:0]  user_set_i,
  output logic [1:0]       sa_match_o,
  output logic             type_match_o,
  output logic             pause_req_o,
  output logic [15:0]      pause_quantum_o,
  output logic             copy_frame_o,
  output logic             mii_select_o,
  output logic             wake_o,
  output logic             irq_o
);

  state_t cur_ff;
  state_t nxt_st;

  logic [47:0] sa3_addr;
  logic [47:0] sa4_addr;
  logic [3:0]  ev;
  logic        arp_hit;
  logic        wake_hit;
  logic        wr_uio;
  logic        wr_ist;

  // Low half of pair three lives in the lower bank
  assign sa3_addr = {cur_ff.sa3_high, sa3_low_i};
  assign sa4_addr = {cur_ff.sa4_high, cur_ff.sa4_low};

  // Zero IP is a wildcard hazard, so it never wakes
  assign arp_hit = wake_i.arp_valid
                 && (wake_i.arp_ip == cur_ff.wake_ip)
                 && (cur_ff.wake_ip != 16'h0000);

  assign wake_hit = (wake_i.magic      && cur_ff.wake_en[0])
                 || (arp_hit           && cur_ff.wake_en[1])
                 || (wake_i.sa1_hit    && cur_ff.wake_en[2])
                 || (wake_i.mcast_hash && cur_ff.wake_en[3]);

  assign wr_uio = wr_i && (addr_i == ADDR_USER_IO);
  assign wr_ist = wr_i && (addr_i == ADDR_IRQ_STAT);

  always_comb begin
    nxt_st = cur_ff;
    nxt_st.sa_match   = 2'b00;
    nxt_st.type_match = 1'b0;
    nxt_st.pause_req  = 1'b0;
    nxt_st.rdata      = 32'h0000_0000;

    // Full 48-bit compare, bit 0 carries the group flag
    if (rx_i.dest_valid) begin
      nxt_st.sa_match[0] = (rx_i.dest_addr == sa3_addr);
      nxt_st.sa_match[1] = (rx_i.dest_addr == sa4_addr);
    end
    if (rx_i.type_valid) begin
      nxt_st.type_match = (rx_i.type_len == cur_ff.type_length_compare);
    end

    // Write one clears; inputs set and win over the clear
    if (wr_uio) begin
      nxt_st.user_bits = cur_ff.user_bits & ~wdata_i[3:0];
    end
    nxt_st.user_bits = nxt_st.user_bits | user_set_i;

    // One frame per change of the send bit, either direction
    nxt_st.pause_prev = cur_ff.user_bits[UIO_PAUSE];
    if (cur_ff.user_bits[UIO_PAUSE] != cur_ff.pause_prev) begin
      nxt_st.pause_req = 1'b1;
      if (cur_ff.user_bits[UIO_ZEROQ]) begin
        nxt_st.pause_quantum = 16'h0000;
      end else begin
        nxt_st.pause_quantum = cur_ff.pause_quantum_value;
      end
    end

    ev = 4'h0;
    ev[IRQ_WAKE]  = wake_hit;
    ev[IRQ_PAUSE] = nxt_st.pause_req;
    ev[IRQ_SA]    = |nxt_st.sa_match;
    ev[IRQ_TYPE]  = nxt_st.type_match;

    if (wr_ist) begin
      nxt_st.irq_status = cur_ff.irq_status & ~wdata_i[3:0];
    end
    nxt_st.irq_status = nxt_st.irq_status | ev;

    // Wake flag clears with its status bit; a new event wins
    if (wr_ist && wdata_i[IRQ_WAKE]) begin
      nxt_st.wake_event_detected = 1'b0;
    end
    if (wake_hit) begin
      nxt_st.wake_event_detected = 1'b1;
    end

    if (wr_i) begin
      unique case (addr_i)
        ADDR_SA3_HIGH: begin
          nxt_st.sa3_high = wdata_i[15:0];
        end
        ADDR_SA4_LOW: begin
          nxt_st.sa4_low = wdata_i;
        end
        ADDR_SA4_HIGH: begin
          nxt_st.sa4_high = wdata_i[15:0];
        end
        ADDR_TYPE_LEN: begin
          nxt_st.type_length_compare = wdata_i[15:0];
        end
        ADDR_PAUSE_Q: begin
          nxt_st.pause_quantum_value = wdata_i[15:0];
        end
        ADDR_WAKE_CFG: begin
          nxt_st.wake_ip = wdata_i[15:0];
          nxt_st.wake_en = wdata_i[WAKE_EN_LO+3:WAKE_EN_LO];
        end
        ADDR_IRQ_MASK: begin
          nxt_st.irq_mask = wdata_i[3:0];
        end
        default: begin
        end
      endcase
    end

    // Read data stands in the cycle after the strobe
    if (rd_i) begin
      unique case (addr_i)
        ADDR_SA3_HIGH: begin
          nxt_st.rdata = {16'h0000, cur_ff.sa3_high};
        end
        ADDR_SA4_LOW: begin
          nxt_st.rdata = cur_ff.sa4_low;
        end
        ADDR_SA4_HIGH: begin
          nxt_st.rdata = {16'h0000, cur_ff.sa4_high};
        end
        ADDR_TYPE_LEN: begin
          nxt_st.rdata = {16'h0000, cur_ff.type_length_compare};
        end
        ADDR_PAUSE_Q: begin
          nxt_st.rdata = {16'h0000, cur_ff.pause_quantum_value};
        end
        ADDR_USER_IO: begin
          nxt_st.rdata[3:0]       = cur_ff.user_bits;
          nxt_st.rdata[UIO_LOOPB] = cfg_i.loopback;
          nxt_st.rdata[UIO_HALFD] = ~cfg_i.full_duplex_select;
          nxt_st.rdata[UIO_BITRT] = cfg_i.bitrate;
          nxt_st.rdata[UIO_SPEED] = cfg_i.speed;
          nxt_st.rdata[UIO_WAKE]  = cur_ff.wake_event_detected;
        end
        ADDR_WAKE_CFG: begin
          nxt_st.rdata = {12'h000, cur_ff.wake_en, cur_ff.wake_ip};
        end
        ADDR_IRQ_STAT: begin
          nxt_st.rdata = {28'h0000000, cur_ff.irq_status};
        end
        ADDR_IRQ_MASK: begin
          nxt_st.rdata = {28'h0000000, cur_ff.irq_mask};
        end
        ADDR_VERSION: begin
          nxt_st.rdata = {PART_REF_VALUE, VERSION_VALUE};
        end
        default: begin
          nxt_st.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Single clock domain: both bus clocks are the same tree
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cur_ff <= '0;
      cur_ff.pause_quantum_value <= PAUSE_Q_RESET;
      cur_ff.wake_ip <= WAKE_IP_RESET;
      cur_ff.wake_en <= WAKE_EN_RESET;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign rdata_o         = cur_ff.rdata;
  assign sa_match_o      = cur_ff.sa_match;
  assign type_match_o    = cur_ff.type_match;
  assign pause_req_o     = cur_ff.pause_req;
  assign pause_quantum_o = cur_ff.pause_quantum;
  assign copy_frame_o    = cur_ff.user_bits[UIO_EXTM]
                         & cfg_i.external_match_enable;
  assign mii_select_o    = cur_ff.user_bits[UIO_IFSEL];
  assign wake_o          = cur_ff.wake_event_detected;
  assign irq_o           = |(cur_ff.irq_status & cur_ff.irq_mask);

endmodule
`default_nettype wire

//--- sim/mac_upper_regs_monitor.sv
// Concurrent checks on the upper MAC register bank ports
`timescale 1ns/1ps
`default_nettype none
module mac_upper_regs_monitor
  import mac_upper_regs_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire rx_frame_t   rx_i,
  input wire wake_src_t   wake_i,
  input wire net_cfg_t    cfg_i,
  input wire logic [3:0]  user_set_i,
  input wire logic [1:0]  sa_match_o,
  input wire logic        pause_req_o,
  input wire logic        copy_frame_o,
  input wire logic        mii_select_o,
  input wire logic        wake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  property p_version;
    rd_i && addr_i == ADDR_VERSION |=> rdata_o == {PART_REF_VALUE, VERSION_VALUE};
  endproperty
  property p_high_rsvd;
    rd_i && (addr_i == ADDR_SA3_HIGH || addr_i == ADDR_SA4_HIGH) |=> rdata_o[31:16] == 16'h0;
  endproperty
  property p_sa_cause;
    sa_match_o != 2'b00 |-> $past(rx_i.dest_valid);
  endproperty
  // A pulse needs a set or a clearing write two edges back
  property p_pause_cause;
    pause_req_o |-> $past(user_set_i[2], 2) || ($past(wr_i, 2) && $past(addr_i, 2) == ADDR_USER_IO);
  endproperty
  property p_copy;
    copy_frame_o |-> cfg_i.external_match_enable;
  endproperty
  property p_no_set;
    !mii_select_o && !user_set_i[0] |=> !mii_select_o;
  endproperty
  property p_wake_hold;
    wake_o && !(wr_i && addr_i == ADDR_IRQ_STAT && wdata_i[IRQ_WAKE]) |=> wake_o;
  endproperty
  property p_wake_cause;
    $rose(wake_o) |-> $past(wake_i.magic || wake_i.arp_valid || wake_i.sa1_hit || wake_i.mcast_hash);
  endproperty
  a_version: assert property (p_version) else $error("bad version read");
  a_high_rsvd: assert property (p_high_rsvd) else $error("reserved bits set");
  a_sa_cause: assert property (p_sa_cause) else $error("match without frame");
  a_pause_cause: assert property (p_pause_cause) else $error("pause without change");
  a_copy: assert property (p_copy) else $error("copy without enable");
  a_no_set: assert property (p_no_set) else $error("write set a bit");
  a_wake_hold: assert property (p_wake_hold) else $error("wake flag lost");
  a_wake_cause: assert property (p_wake_cause) else $error("wake without event");
  c_pause: cover property (pause_req_o);
  c_wake: cover property ($rose(wake_o));
  c_sa4: cover property (sa_match_o == 2'b10);
endmodule
bind mac_upper_regs mac_upper_regs_monitor u_mon (.clk_i(clk_i), .rstn_i(rstn_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .rx_i(rx_i), .wake_i(wake_i), .cfg_i(cfg_i), .user_set_i(user_set_i),
  .sa_match_o(sa_match_o), .pause_req_o(pause_req_o), .copy_frame_o(copy_frame_o),
  .mii_select_o(mii_select_o), .wake_o(wake_o));
`default_nettype wire

//--- sim/phy_frame_src.sv
// Behavioural receive-side event source standing in for the PHY path
`timescale 1ns/1ps
`default_nettype none
module phy_frame_src
  import mac_upper_regs_pkg::*;
(
  input  wire logic [2:0]  cmd_i,
  input  wire logic [47:0] val_i,
  output var  rx_frame_t   rx_o,
  output var  wake_src_t   ev_o
);
  // Idle fields show inverted data, never a stale copy
  assign rx_o = {cmd_i == 3'h1, ~val_i ^ {48{cmd_i == 3'h1}},
                 cmd_i == 3'h2, ~val_i[15:0] ^ {16{cmd_i == 3'h2}}};
  assign ev_o = {cmd_i == 3'h5, cmd_i == 3'h6, cmd_i == 3'h4,
                 ~val_i[15:0] ^ {16{cmd_i == 3'h4}}, cmd_i == 3'h3};
endmodule
`default_nettype wire

//--- sim/tb_mac_upper_regs.sv
// Self-checking bench for the upper MAC register bank
`timescale 1ns/1ps
`default_nettype none
module tb_mac_upper_regs;
  import mac_upper_regs_pkg::*;
  logic clk_i = 0, rstn_i = 0, wr_i = 0, rd_i = 0, pause_req_o, copy_frame_o;
  logic mii_select_o, wake_o, irq_o, type_match_o;
  logic [1:0] sa_match_o;
  logic [15:0] pause_quantum_o;
  logic [7:0] addr_i = 0;
  logic [31:0] wdata_i = 0, rdata_o, sa3_low_i = 32'h89abcdef;
  logic [2:0] cmd = 0;
  logic [47:0] val = 0;
  logic [3:0] user_set_i = 0;
  net_cfg_t cfg_i = 5'b10110;
  rx_frame_t rx_i;
  wake_src_t wake_i;
  logic [2:0] wk [4] = '{3'h3, 3'h4, 3'h6, 3'h5};
  int mismatches = 0, checks = 0;
  initial forever #2.5 clk_i = ~clk_i;
  phy_frame_src u_src (.cmd_i(cmd), .val_i(val), .rx_o(rx_i), .ev_o(wake_i));
  mac_upper_regs dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sa3_low_i(sa3_low_i), .rx_i(rx_i),
    .wake_i(wake_i), .cfg_i(cfg_i), .user_set_i(user_set_i), .sa_match_o(sa_match_o),
    .type_match_o(type_match_o), .pause_req_o(pause_req_o),
    .pause_quantum_o(pause_quantum_o), .copy_frame_o(copy_frame_o),
    .mii_select_o(mii_select_o), .wake_o(wake_o), .irq_o(irq_o));
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  // One-cycle receive event and hardware set pulse
  task automatic ev(input logic [2:0] c, input logic [47:0] v, input logic [3:0] s);
    @(posedge clk_i);
    cmd <= c;
    val <= v;
    user_set_i <= s;
    @(posedge clk_i);
    cmd <= 3'h0;
    user_set_i <= 4'h0;
    #1;
  endtask
  task automatic close_out;
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(ADDR_PAUSE_Q, 32'h0000ffff);
    rd(ADDR_WAKE_CFG, 32'h0000ffff);
    wr(ADDR_VERSION, 32'hffffffff);
    rd(ADDR_VERSION, 32'h00000001);
    rd(8'h00, 32'h0);
    wr(ADDR_SA4_LOW, 32'h44332211);
    wr(ADDR_SA4_HIGH, 32'hffff6655);
    rd(ADDR_SA4_HIGH, 32'h00006655);
    ev(3'h1, 48'h665544332211, 4'h0); chk(sa_match_o, 2'b10);
    ev(3'h1, 48'h665544332210, 4'h0); chk(sa_match_o, 2'b00);
    wr(ADDR_SA3_HIGH, 32'h0000abcd);
    ev(3'h1, {16'habcd, sa3_low_i}, 4'h0); chk(sa_match_o, 2'b01);
    wr(ADDR_TYPE_LEN, 32'h00000800);
    ev(3'h2, 48'h0800, 4'h0); chk(type_match_o, 1'b1);
    ev(3'h2, 48'h0806, 4'h0); chk(type_match_o, 1'b0);
    wr(ADDR_PAUSE_Q, 32'h00001234);
    ev(3'h0, 48'h0, 4'h4);
    @(posedge clk_i) #1 chk({pause_req_o, pause_quantum_o}, 17'h11234);
    @(posedge clk_i) #1 chk(pause_req_o, 1'b0);
    ev(3'h0, 48'h0, 4'h8);
    wr(ADDR_USER_IO, 32'h00000004);
    @(posedge clk_i) #1 chk({pause_req_o, pause_quantum_o}, 17'h10000);
    rd(ADDR_USER_IO, 32'h00090008);
    ev(3'h0, 48'h0, 4'h3); chk({mii_select_o, copy_frame_o}, 2'b10);
    @(posedge clk_i);
    cfg_i.external_match_enable <= 1'b1;
    cfg_i.full_duplex_select <= 1'b0;
    @(posedge clk_i) #1 chk(copy_frame_o, 1'b1);
    wr(ADDR_USER_IO, 32'hffffffff);
    rd(ADDR_USER_IO, 32'h000b0000);
    chk({mii_select_o, copy_frame_o}, 2'b00);
    ev(3'h3, 48'h0, 4'h0); chk(wake_o, 1'b0);
    wr(ADDR_WAKE_CFG, 32'h00020000);
    ev(3'h4, 48'h0, 4'h0); chk(wake_o, 1'b0);
    wr(ADDR_WAKE_CFG, 32'h00025678);
    ev(3'h4, 48'h1234, 4'h0); chk(wake_o, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_WAKE_CFG, 32'h00005678 | (32'h00010000 << i));
      ev(wk[i], 48'h5678, 4'h0); chk(wake_o, 1'b1);
      if (i < 3) wr(ADDR_IRQ_STAT, 32'h00000001);
    end
    rd(ADDR_USER_IO, 32'h001b0000);
    wr(ADDR_IRQ_MASK, 32'h00000001);
    #1 chk(irq_o, 1'b1);
    wr(ADDR_IRQ_STAT, 32'h00000001);
    #1 chk({wake_o, irq_o}, 2'b00);
    close_out;
  end
endmodule
`default_nettype wire
